//--- logic/pump_fault_latch_reset.sv
`timescale 1ns/1ps
// Overview of operation
// - fault B selector: 0 unused, 1-8 base inputs, 9-16 option board inputs
// - selected fault B input at 1 means pump fault, 0 means healthy
// - a faulted pump is excluded from the duty cycle
// - reset selector 0 watches no input; 1-16 chooses the watched input
// - reset contact clears all fault flags of its pump, returning it to duty
// - reset selector configured at index 0 clears every pump
// - contact reset acts only in run or simulate mode, on 0 to 1 edge
// - flags only affect relays whose function code is 50 to 56
// - every fault flag latches and never clears by itself
// - a run, fault A or fault B flag sets the pump failed flag; the efficiency flag sets it only with action 2
// - pump failed holds 1 until communications, programmer or contact reset
// - writing 0 to pump failed clears all flags and efficiency counter
// - run fault reflects run confirmation only after delay has expired
// - low efficiency action: 0 nothing, 1 flag only, 2 flag and failed
// - in run mode symbol flashes, relay unused while failed or manual
// - run confirm delay in seconds 0 to 9999, default 5
// - commanded pump without run confirmation after delay is failed
module pump_fault_latch_reset
	import pump_fault_pkg::*;
#(
	parameter int RELAYS = NUM_RELAYS,
	parameter int CYCLES_PER_SEC = CYCLES_PER_SECOND
)
(
	input wire logic REF_CLK_I,
	input wire logic RESET_I,
	input wire logic CLK_EN_I,
	input wire logic [NUM_INPUTS-1:0] DISCRETE_I,
	input wire logic [1:0] MODE_I,
	input wire logic [RELAYS-1:0] RUN_CMD_I,
	input wire logic [RELAYS-1:0] FAULT_A_IN_I,
	input wire logic [RELAYS-1:0] LOW_EFF_EVENT_I,
	input wire logic [RELAYS-1:0] MANUAL_I,
	input wire logic [RELAYS*FUNC_W-1:0] RELAY_FUNCTION_SELECT_I,
	input wire logic [RELAYS*ACTION_W-1:0] LOW_EFFICIENCY_ACTION_I,
	input wire logic [RELAYS*SEL_W-1:0] RUN_CONFIRM_INPUT_SELECT_I,
	input wire logic [RELAYS*DELAY_W-1:0] RUN_CONFIRM_DELAY_I,
	input wire logic [RELAYS-1:0] COMM_LOW_VOL_CLEAR_I,
	input wire logic PRG_WRITE_I,
	input wire logic [2:0] PRG_REG_I,
	input wire logic [RELAY_W-1:0] PRG_RELAY_I,
	input wire logic [SEL_W-1:0] PRG_WDATA_I,
	input wire logic FLASH_PHASE_I,
	output logic [SEL_W-1:0] PRG_RDATA_O,
	output logic [RELAYS-1:0] PUMP_AVAILABLE_O,
	output logic [RELAYS-1:0] SYMBOL_FLASH_O,
	output logic [RELAYS-1:0] LOW_EFF_COUNT_CLEAR_O
);
	logic [NUM_INPUTS-1:0] din_level;
	logic [NUM_INPUTS-1:0] din_rise;
	logic [SEL_W-1:0] fault_b_input_select [RELAYS];
	logic [SEL_W-1:0] reset_input_select [RELAYS];
	fault_flags_t flags [RELAYS];
	logic [RELAYS-1:0] run_expired;
	logic [RELAYS-1:0] is_pump;
	logic [RELAYS-1:0] contact_clear;
	logic [RELAYS-1:0] prg_clear;
	logic [RELAYS-1:0] any_clear;
	logic all_pump_reset;
	logic reset_mode_ok;
	logic prg_wr_en;

	input_sync #(
		.WIDTH(NUM_INPUTS)
	) u_sync (
		.clk_i(REF_CLK_I),
		.reset_i(RESET_I),
		.enable_i(CLK_EN_I),
		.raw_i(DISCRETE_I),
		.level_o(din_level),
		.rise_o(din_rise)
	);

	assign reset_mode_ok = (MODE_I == MODE_RUN) || (MODE_I == MODE_SIMULATE);
	assign prg_wr_en = CLK_EN_I && PRG_WRITE_I;
	// the selector at index 0 is the global all-pumps reset source
	assign all_pump_reset = reset_mode_ok && pick_input(din_rise, reset_input_select[0]);

	genvar r;
	generate
		for (r = 0; r < RELAYS; r++)
		begin : g_relay
			logic [FUNC_W-1:0] func;
			low_eff_action_t action;
			logic run_ok;
			logic fault_b_now;
			logic run_fault_now;

			assign func = RELAY_FUNCTION_SELECT_I[r*FUNC_W +: FUNC_W];
			assign action = low_eff_action_t'(LOW_EFFICIENCY_ACTION_I[r*ACTION_W +: ACTION_W]);
			assign is_pump[r] = (func >= PUMP_FUNC_LO) && (func <= PUMP_FUNC_HI);

			run_confirm_timer #(
				.CYCLES_PER_SEC(CYCLES_PER_SEC)
			) u_timer (
				.clk_i(REF_CLK_I),
				.reset_i(RESET_I),
				.enable_i(CLK_EN_I),
				.run_cmd_i(RUN_CMD_I[r]),
				.delay_s_i(RUN_CONFIRM_DELAY_I[r*DELAY_W +: DELAY_W]),
				.expired_o(run_expired[r])
			);

			// selector 0 means no interlock, so pick_input yields 0 (healthy)
			assign fault_b_now = pick_input(din_level, fault_b_input_select[r]);
			assign run_ok = pick_input(din_level, RUN_CONFIRM_INPUT_SELECT_I[r*SEL_W +: SEL_W]);
			assign run_fault_now = (RUN_CONFIRM_INPUT_SELECT_I[r*SEL_W +: SEL_W] != SEL_NONE)
				&& RUN_CMD_I[r] && run_expired[r] && !run_ok;

			assign contact_clear[r] = all_pump_reset ||
				(r != 0 && reset_mode_ok && pick_input(din_rise, reset_input_select[r]));
			assign prg_clear[r] = prg_wr_en && PRG_REG_I == REG_PUMP_FAILED &&
				PRG_RELAY_I == RELAY_W'(r) && PRG_WDATA_I[0] == 1'b0;
			assign any_clear[r] = contact_clear[r] || prg_clear[r] || COMM_LOW_VOL_CLEAR_I[r];

			always_ff @(posedge REF_CLK_I)
			begin
				if (RESET_I)
				begin
					fault_b_input_select[r] <= SEL_NONE;
					reset_input_select[r] <= SEL_NONE;
				end
				else if (prg_wr_en && PRG_RELAY_I == RELAY_W'(r))
				begin
					if (PRG_REG_I == REG_FAULT_B_SEL && PRG_WDATA_I <= SEL_MAX)
						fault_b_input_select[r] <= PRG_WDATA_I;
					if (PRG_REG_I == REG_RESET_SEL && PRG_WDATA_I <= SEL_MAX)
						reset_input_select[r] <= PRG_WDATA_I;
				end
			end

			// clear wins only over old state; a fault present in the same cycle still sets
			always_ff @(posedge REF_CLK_I)
			begin
				if (RESET_I)
					flags[r] <= '0;
				else if (CLK_EN_I)
				begin
					if (any_clear[r])
						flags[r] <= '0;
					if (is_pump[r])
					begin
						if (run_fault_now)
						begin
							flags[r].run_fault <= 1'b1;
							flags[r].pump_failed <= 1'b1;
						end
						if (FAULT_A_IN_I[r])
						begin
							flags[r].fault_a <= 1'b1;
							flags[r].pump_failed <= 1'b1;
						end
						if (fault_b_now)
						begin
							flags[r].fault_b <= 1'b1;
							flags[r].pump_failed <= 1'b1;
						end
						if (LOW_EFF_EVENT_I[r] && action != ACT_NONE)
						begin
							flags[r].low_eff_fault <= 1'b1;
							if (action == ACT_ALARM_FAIL)
								flags[r].pump_failed <= 1'b1;
						end
					end
					if (!any_clear[r] && (flags[r].run_fault || flags[r].fault_a || flags[r].fault_b))
						flags[r].pump_failed <= 1'b1;
				end
			end

			assign PUMP_AVAILABLE_O[r] = !(is_pump[r] && (flags[r].pump_failed || MANUAL_I[r]));
			assign SYMBOL_FLASH_O[r] = (MODE_I == MODE_RUN) && is_pump[r] &&
				(flags[r].pump_failed || MANUAL_I[r]) && FLASH_PHASE_I;
			assign LOW_EFF_COUNT_CLEAR_O[r] = CLK_EN_I && any_clear[r];

			failed_holds_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
				(flags[r].pump_failed && CLK_EN_I && !any_clear[r]) |=> flags[r].pump_failed)
				else $error("pump failed flag dropped without a reset source");
			fault_b_latch_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
				(CLK_EN_I && is_pump[r] && fault_b_now) |=> (flags[r].fault_b && flags[r].pump_failed))
				else $error("fault B input did not latch");
			non_pump_quiet_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
				(!is_pump[r] && flags[r] == '0) |=> (flags[r] == '0))
				else $error("non-pump relay picked up a fault flag");
			efficiency_alarm_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
				(CLK_EN_I && is_pump[r] && LOW_EFF_EVENT_I[r] && action == ACT_ALARM && !any_clear[r]
				&& !flags[r].pump_failed && !run_fault_now && !FAULT_A_IN_I[r] && !fault_b_now
				&& !flags[r].fault_a && !flags[r].fault_b && !flags[r].run_fault)
				|=> (flags[r].low_eff_fault && !flags[r].pump_failed))
				else $error("alarm-only efficiency action failed the pump");
			failed_removes_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
				(is_pump[r] && flags[r].pump_failed) |-> !PUMP_AVAILABLE_O[r])
				else $error("failed pump still in duty");
			clear_all_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
				(CLK_EN_I && prg_clear[r] && (!is_pump[r]
				|| !(run_fault_now || FAULT_A_IN_I[r] || fault_b_now || LOW_EFF_EVENT_I[r])))
				|=> (flags[r] == '0))
				else $error("programmer clear left flags set");
			run_fault_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
				(CLK_EN_I && is_pump[r] && run_fault_now) |=> flags[r].run_fault)
				else $error("run fault not latched after delay");
			fault_a_latch_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
				(CLK_EN_I && is_pump[r] && FAULT_A_IN_I[r]) |=> (flags[r].fault_a && flags[r].pump_failed))
				else $error("fault A input did not fail the pump");
			flags_latched_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
				(CLK_EN_I && !any_clear[r]) |=> ((flags[r].run_fault || !$past(flags[r].run_fault))
				&& (flags[r].low_eff_fault || !$past(flags[r].low_eff_fault))
				&& (flags[r].fault_a || !$past(flags[r].fault_a))
				&& (flags[r].fault_b || !$past(flags[r].fault_b))))
				else $error("fault flag cleared by itself");
			efficiency_fail_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
				(CLK_EN_I && is_pump[r] && LOW_EFF_EVENT_I[r] && action == ACT_ALARM_FAIL)
				|=> (flags[r].low_eff_fault && flags[r].pump_failed))
				else $error("efficiency fail action did not fail the pump");
			efficiency_none_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
				(CLK_EN_I && action == ACT_NONE && !flags[r].low_eff_fault) |=> !flags[r].low_eff_fault)
				else $error("efficiency flag set with no action selected");
			enable_freeze_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
				!CLK_EN_I |=> $stable(flags[r]))
				else $error("flags moved while the clock enable was low");
		end
	endgenerate

	contact_mode_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
		!reset_mode_ok |-> (contact_clear == '0))
		else $error("reset contact acted outside run or simulate");
	global_reset_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
		all_pump_reset |-> (contact_clear == '1))
		else $error("global contact did not reach every pump");
	rdata_range_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
		PRG_RDATA_O <= SEL_MAX)
		else $error("read data above the selector range");

	// read mux, registered so data comes from flops
	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I)
			PRG_RDATA_O <= '0;
		else if (CLK_EN_I)
		begin
			case (reg_sel_t'(PRG_REG_I))
				REG_FAULT_B_SEL: PRG_RDATA_O <= fault_b_input_select[PRG_RELAY_I];
				REG_RESET_SEL: PRG_RDATA_O <= reset_input_select[PRG_RELAY_I];
				REG_PUMP_FAILED: PRG_RDATA_O <= {4'h0, flags[PRG_RELAY_I].pump_failed};
				REG_RUN_FAULT: PRG_RDATA_O <= {4'h0, flags[PRG_RELAY_I].run_fault};
				REG_LOW_EFF_FAULT: PRG_RDATA_O <= {4'h0, flags[PRG_RELAY_I].low_eff_fault};
				REG_FAULT_A: PRG_RDATA_O <= {4'h0, flags[PRG_RELAY_I].fault_a};
				REG_FAULT_B: PRG_RDATA_O <= {4'h0, flags[PRG_RELAY_I].fault_b};
				default: PRG_RDATA_O <= '0;
			endcase
		end
	end
endmodule

//--- common/pump_fault_pkg.sv
package pump_fault_pkg;
	localparam int NUM_RELAYS = 8;
	localparam int NUM_INPUTS = 16;
	localparam int SEL_W = 5;
	localparam int RELAY_W = 3;
	localparam int FUNC_W = 7;
	localparam int ACTION_W = 2;
	localparam int DELAY_W = 14;
	localparam int COUNT_W = 8;
	localparam logic [SEL_W-1:0] SEL_NONE = 5'h00;
	localparam logic [SEL_W-1:0] SEL_BASE_LAST = 5'h08;
	localparam logic [SEL_W-1:0] SEL_MAX = 5'h10;
	localparam logic [FUNC_W-1:0] PUMP_FUNC_LO = 7'h32;
	localparam logic [FUNC_W-1:0] PUMP_FUNC_HI = 7'h38;
	localparam logic [DELAY_W-1:0] RUN_DELAY_RESET = 14'h0005;
	localparam logic [DELAY_W-1:0] RUN_DELAY_MAX = 14'h270f;
	localparam int CLOCK_HZ = 25000000;
	localparam int SECOND_S = 1;
	localparam int CYCLES_PER_SECOND = CLOCK_HZ * SECOND_S;

	// register selector for programmer access, one per relay
	typedef enum logic [2:0]
	{
		REG_FAULT_B_SEL = 3'b000,
		REG_RESET_SEL = 3'b001,
		REG_PUMP_FAILED = 3'b010,
		REG_RUN_FAULT = 3'b011,
		REG_LOW_EFF_FAULT = 3'b100,
		REG_FAULT_A = 3'b101,
		REG_FAULT_B = 3'b110
	} reg_sel_t;

	typedef enum logic [1:0]
	{
		ACT_NONE = 2'b00,
		ACT_ALARM = 2'b01,
		ACT_ALARM_FAIL = 2'b10
	} low_eff_action_t;

	typedef enum logic [1:0]
	{
		MODE_PROGRAM = 2'b00,
		MODE_RUN = 2'b01,
		MODE_SIMULATE = 2'b10
	} op_mode_t;

	typedef struct packed
	{
		logic pump_failed;
		logic run_fault;
		logic low_eff_fault;
		logic fault_a;
		logic fault_b;
	} fault_flags_t;

	function automatic logic pick_input(input logic [NUM_INPUTS-1:0] inputs, input logic [SEL_W-1:0] sel);
		logic result;
		result = 1'b0;
		if (sel != SEL_NONE && sel <= SEL_MAX)
			result = inputs[4'(sel - 5'h01)];
		return result;
	endfunction
endpackage

//--- logic/input_sync.sv
`timescale 1ns/1ps
module input_sync
	import pump_fault_pkg::*;
#(
	parameter int WIDTH = NUM_INPUTS
)
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic enable_i,
	input wire logic [WIDTH-1:0] raw_i,
	output logic [WIDTH-1:0] level_o,
	output logic [WIDTH-1:0] rise_o
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// stage1 feeds only stage2; edges are taken from the later pair
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end
		else if (enable_i)
		begin
			stage1 <= raw_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	assign level_o = stage2;
	assign rise_o = enable_i ? (stage2 & ~stage3) : '0;
endmodule

//--- logic/run_confirm_timer.sv
`timescale 1ns/1ps
module run_confirm_timer
	import pump_fault_pkg::*;
#(
	parameter int CYCLES_PER_SEC = CYCLES_PER_SECOND
)
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic enable_i,
	input wire logic run_cmd_i,
	input wire logic [DELAY_W-1:0] delay_s_i,
	output logic expired_o
);
	logic [31:0] tick;
	logic [DELAY_W-1:0] seconds;
	logic tick_done;

	assign tick_done = (tick == 32'(CYCLES_PER_SEC - 1));

	// delay restarts every time the run command drops
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			tick <= '0;
			seconds <= '0;
			expired_o <= 1'b0;
		end
		else if (enable_i)
		begin
			if (!run_cmd_i)
			begin
				tick <= '0;
				seconds <= '0;
				expired_o <= 1'b0;
			end
			else if (!expired_o)
			begin
				if (seconds >= delay_s_i)
					expired_o <= 1'b1;
				else if (tick_done)
				begin
					tick <= '0;
					seconds <= seconds + 14'h0001;
				end
				else
					tick <= tick + 32'h1;
			end
		end
	end
endmodule

//--- tb/contact_model.sv
`timescale 1ns/1ps
module contact_model
(
	input wire logic clk_i,
	output logic [15:0] contacts_o,
	output logic [7:0] comm_clear_o
);
	initial
	begin
		contacts_o = 16'h0000;
		comm_clear_o = 8'h00;
	end
	// contacts move after the falling edge, well away from the sampling edge
	task automatic set_contact(input int n, input logic v);
		@(negedge clk_i);
		contacts_o[n-1] = v;
	endtask
	// momentary button, held long enough to pass the three-flop synchroniser and edge detector
	task automatic press(input int n);
		set_contact(n, 1'b1);
		repeat (5) @(negedge clk_i);
		contacts_o[n-1] = 1'b0;
		repeat (4) @(negedge clk_i);
	endtask
	task automatic comm_clear(input int r);
		@(negedge clk_i);
		comm_clear_o[r] = 1'b1;
		@(negedge clk_i);
		comm_clear_o[r] = 1'b0;
	endtask
endmodule

//--- tb/test_pump_fault_latch_reset.sv
`timescale 1ns/1ps
module test_pump_fault_latch_reset
	import pump_fault_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic en = 1'b1;
	logic [1:0] mode = 2'h1;
	logic [7:0] run_cmd = 8'h00;
	logic [7:0] fault_a = 8'h00;
	logic [7:0] low_eff = 8'h00;
	logic [7:0] manual = 8'h00;
	logic [55:0] func = {8{7'h32}};
	logic [15:0] act = 16'h0000;
	logic [39:0] rc_sel = 40'h0;
	logic [111:0] delay = {8{14'h0002}};
	logic wr = 1'b0;
	logic [2:0] rsel = 3'h0;
	logic [2:0] rly = 3'h0;
	logic [4:0] wdata = 5'h00;
	logic phase = 1'b1;
	logic [15:0] contacts;
	logic [7:0] comm_clr;
	logic [4:0] rdata;
	logic [7:0] avail;
	logic [7:0] flash;
	logic [7:0] cnt_clr;
	int bad_count = 0;
	int total_checks = 0;
	always #20 clk = ~clk;
	// short second so the run-confirm delay lasts a few cycles
	pump_fault_latch_reset #(.CYCLES_PER_SEC(4)) pump_fault_latch_reset_inst
	(
		.REF_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(en), .DISCRETE_I(contacts), .MODE_I(mode),
		.RUN_CMD_I(run_cmd), .FAULT_A_IN_I(fault_a), .LOW_EFF_EVENT_I(low_eff), .MANUAL_I(manual),
		.RELAY_FUNCTION_SELECT_I(func), .LOW_EFFICIENCY_ACTION_I(act), .RUN_CONFIRM_INPUT_SELECT_I(rc_sel),
		.RUN_CONFIRM_DELAY_I(delay), .COMM_LOW_VOL_CLEAR_I(comm_clr), .PRG_WRITE_I(wr), .PRG_REG_I(rsel),
		.PRG_RELAY_I(rly), .PRG_WDATA_I(wdata), .FLASH_PHASE_I(phase), .PRG_RDATA_O(rdata),
		.PUMP_AVAILABLE_O(avail), .SYMBOL_FLASH_O(flash), .LOW_EFF_COUNT_CLEAR_O(cnt_clr)
	);
	contact_model contact_model_inst
	(
		.clk_i(clk),
		.contacts_o(contacts),
		.comm_clear_o(comm_clr)
	);
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [2:0] r, input logic [2:0] rl, input logic [4:0] d);
		@(negedge clk);
		wr = 1'b1;
		rsel = r;
		rly = rl;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [2:0] r, input logic [2:0] rl, input logic [4:0] exp);
		@(negedge clk);
		rsel = r;
		rly = rl;
		@(negedge clk);
		check(what, {3'h0, rdata}, {3'h0, exp});
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (100000) @(posedge clk);
		bad_count++;
		results();
	end
	initial
	begin
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 8; i++)
			rd_chk("reset value", 3'(i), 3'h1, 5'h00);
		check("available", avail, 8'hff);
		wr_reg(REG_FAULT_B_SEL, 3'h1, 5'h03);
		contact_model_inst.set_contact(3, 1'b1);
		repeat (6) @(negedge clk);
		rd_chk("fault b", REG_FAULT_B, 3'h1, 5'h01);
		rd_chk("failed", REG_PUMP_FAILED, 3'h1, 5'h01);
		check("available", avail, 8'hfd);
		check("flash", flash, 8'h02);
		contact_model_inst.set_contact(3, 1'b0);
		repeat (6) @(negedge clk);
		rd_chk("fault b held", REG_FAULT_B, 3'h1, 5'h01);
		wr_reg(REG_RESET_SEL, 3'h1, 5'h11);
		rd_chk("reset sel", REG_RESET_SEL, 3'h1, 5'h00);
		wr_reg(REG_RESET_SEL, 3'h1, 5'h05);
		mode = 2'h0;
		contact_model_inst.press(5);
		rd_chk("program mode", REG_PUMP_FAILED, 3'h1, 5'h01);
		mode = 2'h2;
		contact_model_inst.press(5);
		rd_chk("contact clear", REG_FAULT_B, 3'h1, 5'h00);
		rd_chk("contact failed", REG_PUMP_FAILED, 3'h1, 5'h00);
		contact_model_inst.set_contact(5, 1'b1);
		repeat (6) @(negedge clk);
		fault_a[1] = 1'b1;
		repeat (2) @(negedge clk);
		fault_a[1] = 1'b0;
		repeat (4) @(negedge clk);
		rd_chk("steady level", REG_PUMP_FAILED, 3'h1, 5'h01);
		contact_model_inst.set_contact(5, 1'b0);
		@(negedge clk);
		wr = 1'b1;
		rsel = REG_PUMP_FAILED;
		rly = 3'h1;
		wdata = 5'h00;
		#1 check("count clear", cnt_clr, 8'h02);
		@(negedge clk);
		wr = 1'b0;
		rd_chk("prog clear", REG_FAULT_A, 3'h1, 5'h00);
		mode = 2'h1;
		for (int a = 0; a < 3; a++)
		begin
			act[3:2] = a[1:0];
			@(negedge clk);
			low_eff[1] = 1'b1;
			@(negedge clk);
			low_eff[1] = 1'b0;
			repeat (3) @(negedge clk);
			rd_chk("low eff", REG_LOW_EFF_FAULT, 3'h1, 5'(a > 0));
			rd_chk("low eff failed", REG_PUMP_FAILED, 3'h1, 5'(a == 2));
			contact_model_inst.comm_clear(1);
			rd_chk("comm clear", REG_LOW_EFF_FAULT, 3'h1, 5'h00);
		end
		func[20:14] = 7'h00;
		@(negedge clk);
		fault_a = 8'h0e;
		repeat (2) @(negedge clk);
		fault_a = 8'h00;
		repeat (3) @(negedge clk);
		rd_chk("not a pump", REG_PUMP_FAILED, 3'h2, 5'h00);
		rd_chk("pump three", REG_PUMP_FAILED, 3'h3, 5'h01);
		wr_reg(REG_RESET_SEL, 3'h0, 5'h06);
		contact_model_inst.press(6);
		rd_chk("all one", REG_PUMP_FAILED, 3'h1, 5'h00);
		rd_chk("all three", REG_PUMP_FAILED, 3'h3, 5'h00);
		manual[4] = 1'b1;
		@(negedge clk);
		check("manual available", avail, 8'hef);
		check("manual flash", flash, 8'h10);
		phase = 1'b0;
		#1 check("flash phase", flash, 8'h00);
		phase = 1'b1;
		manual[4] = 1'b0;
		rc_sel[19:15] = 5'h07;
		delay[55:42] = 14'h0003;
		run_cmd[3] = 1'b1;
		@(negedge clk);
		rd_chk("run delay", REG_RUN_FAULT, 3'h3, 5'h00);
		repeat (8) @(negedge clk);
		rd_chk("still delayed", REG_RUN_FAULT, 3'h3, 5'h00);
		repeat (2) @(negedge clk);
		rd_chk("run fault", REG_RUN_FAULT, 3'h3, 5'h01);
		rd_chk("run failed", REG_PUMP_FAILED, 3'h3, 5'h01);
		// a fault seen only while the enable is low must not latch
		run_cmd[3] = 1'b0;
		en = 1'b0;
		fault_a[5] = 1'b1;
		repeat (2) @(negedge clk);
		fault_a[5] = 1'b0;
		@(negedge clk);
		en = 1'b1;
		rd_chk("frozen", REG_PUMP_FAILED, 3'h5, 5'h00);
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		rd_chk("reset failed", REG_PUMP_FAILED, 3'h3, 5'h00);
		rd_chk("reset selector", REG_RESET_SEL, 3'h0, 5'h00);
		results();
	end
endmodule
